//--- qdac_pkg.sv
package qdac_pkg;
	// ==========================================
	// Frame layout
	localparam int FRAME_BITS = 24;
	localparam int CMD_MSB = 23;
	localparam int CMD_LSB = 20;
	localparam int ADDR_MSB = 19;
	localparam int ADDR_LSB = 16;
	localparam int DATA_MSB = 15;
	localparam int CHANNELS = 4;
	localparam int REF_BIT = 0;
	// ==========================================
	// Commands
	localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
	localparam logic [3:0] CMD_UPDATE_CHAN = 4'h2;
	localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
	localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
	localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
	localparam logic [3:0] CMD_REF_SETUP = 4'h7;
	// ==========================================
	// Reset values and codes
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic REF_RESET = 1'b0;
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MID = 16'h8000;
	localparam logic [4:0] BIT_COUNT_RESET = 5'h00;
	typedef enum logic [1:0] {
		QDAC_INIT = 2'b00,
		QDAC_RUN = 2'b01,
		QDAC_HOLD = 2'b10
	} qdac_state_t;
endpackage

//--- qdac_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for one pin; first flop read only by second
module qdac_sync (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic reset_value,
	input wire logic pin,
	output logic pin_sync
);
	logic stage;
	logic held;
	// ==========================================
	// Flops clear to a constant and hold the pin relative to reset_value,
	// so each pin leaves reset at its own reset_value without a false edge
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			stage <= 1'b0;
			held <= 1'b0;
		end else begin
			stage <= pin ^ reset_value;
			held <= stage;
		end
	end
	// Undo the relative storage on the way out
	assign pin_sync = held ^ reset_value;
endmodule // qdac_sync

//--- qdac_chan_mem.sv
`timescale 1ns/1ps
// Four-word register bank, registered read
module qdac_chan_mem (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [3:0] wr_en,
	input wire logic [15:0] wr_data,
	input wire logic [1:0] rd_addr,
	output logic [15:0] rd_data,
	output logic [63:0] all_data
);
	logic [15:0] mem [4];
	// ==========================================
	// Per-word write, read out through a flop
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				mem[i] <= 16'h0000;
			end
			rd_data <= 16'h0000;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_en[i]) begin
					mem[i] <= wr_data;
				end
			end
			rd_data <= mem[rd_addr];
		end
	end
	assign all_data = {mem[3], mem[2], mem[1], mem[0]};
endmodule // qdac_chan_mem

//--- qdac_ctrl.sv
`timescale 1ns/1ps
module qdac_ctrl (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic serial_clk,
	input wire logic serial_in,
	input wire logic sync_n,
	input wire logic load_strobe_n,
	input wire logic hw_reset_n,
	input wire logic reset_level_select,
	output logic [15:0] chan_a,
	output logic [15:0] chan_b,
	output logic [15:0] chan_c,
	output logic [15:0] chan_d,
	output logic [3:0] load_strobe_mask,
	output logic ref_enable,
	output logic ready
);
	import qdac_pkg::*;
	// ==========================================
	// Pin synchronisers
	logic sclk_s, sdi_s, sync_s, strobe_s, rstn_s, sel_s;
	// Serial clock idles high
	qdac_sync u_s0 (
		.clk_sys(clk_sys),
		.reset(reset),
		.reset_value(1'b1),
		.pin(serial_clk),
		.pin_sync(sclk_s)
	);
	// Serial data idles low
	qdac_sync u_s1 (
		.clk_sys(clk_sys),
		.reset(reset),
		.reset_value(1'b0),
		.pin(serial_in),
		.pin_sync(sdi_s)
	);
	// Frame sync idles high, so no false rise after reset
	qdac_sync u_s2 (
		.clk_sys(clk_sys),
		.reset(reset),
		.reset_value(1'b1),
		.pin(sync_n),
		.pin_sync(sync_s)
	);
	// Load strobe idles high
	qdac_sync u_s3 (
		.clk_sys(clk_sys),
		.reset(reset),
		.reset_value(1'b1),
		.pin(load_strobe_n),
		.pin_sync(strobe_s)
	);
	// Reset pin leaves reset low: init waits until the pin is really seen high
	qdac_sync u_s4 (
		.clk_sys(clk_sys),
		.reset(reset),
		.reset_value(1'b0),
		.pin(hw_reset_n),
		.pin_sync(rstn_s)
	);
	// Level select, only read once its flops hold the pin
	qdac_sync u_s5 (
		.clk_sys(clk_sys),
		.reset(reset),
		.reset_value(1'b0),
		.pin(reset_level_select),
		.pin_sync(sel_s)
	);

	// Delayed copies for edge detection, preset to the idle levels
	logic sclk_d, sync_d, strobe_d;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sclk_d <= 1'b1;
			sync_d <= 1'b1;
			strobe_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			sync_d <= sync_s;
			strobe_d <= strobe_s;
		end
	end
	// One-cycle edge pulses
	logic sclk_fall, sync_rise, strobe_fall;
	assign sclk_fall = sclk_d & ~sclk_s;
	assign sync_rise = ~sync_d & sync_s;
	assign strobe_fall = strobe_d & ~strobe_s;

	// ==========================================
	// Power-on state: wait for reset pin high before running
	qdac_state_t state;
	logic [15:0] clear_code;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= QDAC_INIT;
			clear_code <= CODE_ZERO;
		end else begin
			case (state)
				QDAC_INIT: begin
					if (rstn_s) begin
						state <= QDAC_RUN;
						clear_code <= sel_s ? CODE_MID : CODE_ZERO;
					end
				end
				QDAC_RUN: begin
					if (!rstn_s) begin
						state <= QDAC_HOLD;
						clear_code <= sel_s ? CODE_MID : CODE_ZERO;
					end
				end
				QDAC_HOLD: begin
					if (rstn_s) begin
						state <= QDAC_RUN;
					end
				end
				default: state <= QDAC_INIT;
			endcase
		end
	end
	logic running;
	assign running = (state == QDAC_RUN);

	// ==========================================
	// Shift register, MSB first, sampled on clock fall while sync low
	logic [23:0] shift;
	logic [4:0] bit_count;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			shift <= 24'h000000;
			bit_count <= BIT_COUNT_RESET;
		end else if (sync_s) begin
			bit_count <= BIT_COUNT_RESET;
		end else if (sclk_fall) begin
			shift <= {shift[22:0], sdi_s};
			if (bit_count != 5'(FRAME_BITS)) begin
				bit_count <= bit_count + 5'h01;
			end
		end
	end

	// Frame acted on at sync rise, needs full 24 bits
	logic frame_go;
	assign frame_go = sync_rise && (bit_count == 5'(FRAME_BITS)) && running;
	logic [3:0] cmd_field;
	logic [3:0] addr;
	logic [15:0] data;
	assign cmd_field = shift[CMD_MSB:CMD_LSB];
	assign addr = shift[ADDR_MSB:ADDR_LSB];
	assign data = shift[DATA_MSB:0];

	// ==========================================
	// Software registers
	logic soft_reset;
	assign soft_reset = frame_go && (cmd_field == CMD_SOFT_RESET);
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			load_strobe_mask <= MASK_RESET;
			ref_enable <= ~REF_RESET;
		end else if (soft_reset) begin
			load_strobe_mask <= MASK_RESET;
			ref_enable <= ~REF_RESET;
		end else if (frame_go && cmd_field == CMD_LOAD_MASK) begin
			load_strobe_mask <= data[3:0];
		end else if (frame_go && cmd_field == CMD_REF_SETUP) begin
			ref_enable <= ~data[REF_BIT];
		end
	end

	// ==========================================
	// Input registers and channel registers
	logic [63:0] inp_all;
	logic [3:0] inp_we, chan_we;
	logic [3:0] eff_strobe_low;
	logic [3:0] chan_src_new;
	logic [15:0] chan_q [4];
	logic strobe_ok;
	// Strobe disregarded before init and while reset pin low
	assign strobe_ok = running;
	// Per-channel enables; a frame and a strobe fall may share one cycle
	always_comb begin
		inp_we = 4'h0;
		chan_we = 4'h0;
		chan_src_new = 4'h0;
		eff_strobe_low = 4'h0;
		for (int i = 0; i < CHANNELS; i++) begin
			// Masked channel sees strobe as high
			eff_strobe_low[i] = ~strobe_s & ~load_strobe_mask[i];
			if (frame_go && addr[i]) begin
				if (cmd_field == CMD_WRITE_INPUT) begin
					inp_we[i] = 1'b1;
					// Held-low strobe updates even masked channels
					if (~strobe_s) begin
						chan_we[i] = 1'b1;
						chan_src_new[i] = 1'b1;
					end
				end else if (cmd_field == CMD_UPDATE_CHAN) begin
					chan_we[i] = 1'b1;
				end else if (cmd_field == CMD_WRITE_UPDATE) begin
					inp_we[i] = 1'b1;
					chan_we[i] = 1'b1;
					chan_src_new[i] = 1'b1;
				end
			end
			// A fall counts only where the channel sees the pin go low
			if (strobe_fall && strobe_ok && eff_strobe_low[i]) begin
				chan_we[i] = 1'b1;
			end
		end
	end
	// Input registers; all four words are needed at once for a strobe fall
	qdac_chan_mem u_inp (
		.clk_sys(clk_sys),
		.reset(reset),
		.wr_en(inp_we),
		.wr_data(data),
		.rd_addr(2'b00),
		.rd_data(),
		.all_data(inp_all)
	);

	// ==========================================
	// Channel registers; reset pin low refuses writes
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				chan_q[i] <= CODE_ZERO;
			end
		end else if (state != QDAC_RUN) begin
			for (int i = 0; i < 4; i++) begin
				chan_q[i] <= (state == QDAC_HOLD || rstn_s) ?
					(sel_s && state == QDAC_INIT ? CODE_MID : clear_code) : chan_q[i];
			end
		end else if (soft_reset) begin
			for (int i = 0; i < 4; i++) begin
				chan_q[i] <= clear_code;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (chan_we[i]) begin
					chan_q[i] <= chan_src_new[i] ? data : inp_all[16*i +: 16];
				end
			end
		end
	end

	// Outputs straight from flops
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			chan_a <= CODE_ZERO;
			chan_b <= CODE_ZERO;
			chan_c <= CODE_ZERO;
			chan_d <= CODE_ZERO;
			ready <= 1'b0;
		end else begin
			chan_a <= chan_q[0];
			chan_b <= chan_q[1];
			chan_c <= chan_q[2];
			chan_d <= chan_q[3];
			ready <= running;
		end
	end

	// ==========================================
	// Checks
	mask_load_a: assert property (@(posedge clk_sys) disable iff (reset)
		(frame_go && cmd_field == CMD_LOAD_MASK && !soft_reset)
		|=> load_strobe_mask == $past(data[3:0]))
		else $error("mask not loaded");
	ref_setup_a: assert property (@(posedge clk_sys) disable iff (reset)
		(frame_go && cmd_field == CMD_REF_SETUP) |=> ref_enable == !$past(data[0]))
		else $error("reference bit wrong");
	write_upd_a: assert property (@(posedge clk_sys) disable iff (reset)
		(frame_go && cmd_field == CMD_WRITE_UPDATE && addr[1]) |=> ##1 chan_b == $past(data, 2))
		else $error("write-update missed");
	masked_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
		(running && strobe_fall && load_strobe_mask[0] && !frame_go)
		|=> chan_q[0] == $past(chan_q[0]))
		else $error("masked channel moved");
	// Unmasked channel takes its input word on a strobe fall
	strobe_upd_a: assert property (@(posedge clk_sys) disable iff (reset)
		(running && strobe_fall && !load_strobe_mask[1] && !frame_go)
		|=> chan_q[1] == $past(inp_all[31:16]))
		else $error("strobe update missed");
	// Update command copies input, leaves inputs alone
	update_chan_a: assert property (@(posedge clk_sys) disable iff (reset)
		(frame_go && cmd_field == CMD_UPDATE_CHAN && addr[0])
		|=> chan_q[0] == $past(inp_all[15:0]) && inp_all == $past(inp_all))
		else $error("update command wrong");
	// Input write with strobe high leaves the channel register
	write_input_a: assert property (@(posedge clk_sys) disable iff (reset)
		(frame_go && cmd_field == CMD_WRITE_INPUT && addr[0] && strobe_s)
		|=> chan_q[0] == $past(chan_q[0]) && inp_all[15:0] == $past(data))
		else $error("input write wrong");
	// Held-low strobe passes the write even through a mask
	held_low_a: assert property (@(posedge clk_sys) disable iff (reset)
		(frame_go && cmd_field == CMD_WRITE_INPUT && addr[3] && !strobe_s)
		|=> chan_q[3] == $past(data))
		else $error("held strobe ignored");
	hold_block_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state == QDAC_HOLD) ##1 (state == QDAC_HOLD) |-> chan_q[0] == clear_code)
		else $error("update during reset");
	init_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state == QDAC_INIT && !rstn_s) |=> state == QDAC_INIT)
		else $error("init left early");
	shift_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
		sync_s |=> bit_count == BIT_COUNT_RESET)
		else $error("shift while sync high");
	soft_rst_a: assert property (@(posedge clk_sys) disable iff (reset)
		(running && soft_reset) |=> load_strobe_mask == MASK_RESET && chan_q[1] == clear_code)
		else $error("soft reset incomplete");
	// Reset pin clears to the level picked when it went low
	hw_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state == QDAC_RUN && !rstn_s)
		|=> ##1 chan_q[2] == ($past(sel_s, 2) ? CODE_MID : CODE_ZERO))
		else $error("reset pin clear wrong");
	// Leaving init sets the power-up level from the select pin
	power_up_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state == QDAC_INIT && rstn_s)
		|=> chan_q[3] == ($past(sel_s) ? CODE_MID : CODE_ZERO))
		else $error("power-up level wrong");
	// Channel 0 holds, strobe included, until init completes
	init_freeze_a: assert property (@(posedge clk_sys) disable iff (reset)
		(state == QDAC_INIT && !rstn_s) |=> chan_q[0] == $past(chan_q[0]))
		else $error("channel moved in init");
endmodule // qdac_ctrl

//--- qdac_host.sv
`timescale 1ns/1ps
// ==========================================
// Host serial port model: clock idles high, data launched on the rise
module qdac_host (
	output logic serial_clk,
	output logic serial_in,
	output logic sync_n
);
	// Idle levels; clock stands still outside frames
	initial begin
		serial_clk = 1'b1;
		serial_in = 1'b0;
		sync_n = 1'b1;
	end
	// Shift n bits MSB first; caller picks n to make short frames on purpose
	task automatic send(input logic [23:0] w, input int n);
		sync_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_in = w[23 - i];
			#25 serial_clk = 1'b0;
			#25 serial_clk = 1'b1;
		end
		#25 sync_n = 1'b1;
		serial_in = ~serial_in; // Released line shows no stale bit
		#100;
	endtask
endmodule // qdac_host

//--- test_quad_dac_update_and_reset_control.sv
`timescale 1ns/1ps
module test_quad_dac_update_and_reset_control;
	import qdac_pkg::*;
	typedef struct packed {
		logic [23:0] f;
		logic p;
		logic [15:0] a, b, c, d;
		logic [3:0] m;
		logic r;
	} qdac_row_t;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic load_strobe_n = 1'b1;
	logic hw_reset_n = 1'b1;
	logic reset_level_select = 1'b0;
	logic serial_clk, serial_in, sync_n;
	logic [15:0] chan_a, chan_b, chan_c, chan_d;
	logic [3:0] load_strobe_mask;
	logic ref_enable, ready;
	logic [68:0] seen;
	int failures = 0;
	int n_compared = 0;
	// ==========================================
	// Frame, strobe pulse after it, then expected channels, mask, reference
	localparam qdac_row_t ROWS [10] = '{
		'{24'h111234, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 4'h0, 1'b1},
		'{24'h210000, 1'b0, 16'h1234, 16'h0, 16'h0, 16'h0, 4'h0, 1'b1},
		'{24'h325678, 1'b0, 16'h1234, 16'h5678, 16'h0, 16'h0, 4'h0, 1'b1},
		'{24'h149abc, 1'b0, 16'h1234, 16'h5678, 16'h0, 16'h0, 4'h0, 1'b1},
		'{24'h500005, 1'b0, 16'h1234, 16'h5678, 16'h0, 16'h0, 4'h5, 1'b1},
		'{24'h112222, 1'b0, 16'h1234, 16'h5678, 16'h0, 16'h0, 4'h5, 1'b1},
		'{24'h181111, 1'b1, 16'h1234, 16'h5678, 16'h0, 16'h1111, 4'h5, 1'b1},
		'{24'h500000, 1'b1, 16'h2222, 16'h5678, 16'h9abc, 16'h1111, 4'h0, 1'b1},
		'{24'h700001, 1'b0, 16'h2222, 16'h5678, 16'h9abc, 16'h1111, 4'h0, 1'b0},
		'{24'h600000, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 4'h0, 1'b1}
	};

	// 200 MHz system clock
	always #2.5 clk_sys = ~clk_sys;

	assign seen = {chan_a, chan_b, chan_c, chan_d, load_strobe_mask, ref_enable};

	qdac_host u_host (
		.serial_clk(serial_clk),
		.serial_in(serial_in),
		.sync_n(sync_n)
	);

	qdac_ctrl u_dut (
		.clk_sys(clk_sys),
		.reset(reset),
		.serial_clk(serial_clk),
		.serial_in(serial_in),
		.sync_n(sync_n),
		.load_strobe_n(load_strobe_n),
		.hw_reset_n(hw_reset_n),
		.reset_level_select(reset_level_select),
		.chan_a(chan_a),
		.chan_b(chan_b),
		.chan_c(chan_c),
		.chan_d(chan_d),
		.load_strobe_mask(load_strobe_mask),
		.ref_enable(ref_enable),
		.ready(ready)
	);

	// ==========================================
	// Checking and closing
	task automatic check(input logic [69:0] got, input logic [69:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Long enough for synchroniser and output register to land
	task automatic settle;
		repeat (20) @(negedge clk_sys);
	endtask

	// Strobe low pulse, slow enough for the synchroniser to see it
	task automatic pulse;
		load_strobe_n = 1'b0;
		settle;
		load_strobe_n = 1'b1;
		settle;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		settle;
		check({seen, ready}, {64'h0, MASK_RESET, 1'b1, 1'b1});
		foreach (ROWS[i]) begin
			u_host.send(ROWS[i].f, 24);
			settle;
			if (ROWS[i].p)
				pulse;
			check({seen, ready}, {ROWS[i][68:0], 1'b1});
		end
		// Short frame must be dropped
		u_host.send(24'h31abcd, 23);
		settle;
		check({seen, ready}, {64'h0, 4'h0, 1'b1, 1'b1});
		// Strobe held low overrides a full mask
		u_host.send(24'h50000f, 24);
		load_strobe_n = 1'b0;
		u_host.send(24'h1f4321, 24);
		settle;
		check({seen, ready}, {{4{16'h4321}}, 4'hf, 1'b1, 1'b1});
		u_host.send(24'h500000, 24);
		load_strobe_n = 1'b1;
		// Reset pin clears to midscale and blocks writes
		reset_level_select = 1'b1;
		hw_reset_n = 1'b0;
		settle;
		u_host.send(24'h3faaaa, 24);
		settle;
		check({seen, ready}, {{4{CODE_MID}}, 4'h0, 1'b1, 1'b0});
		hw_reset_n = 1'b1;
		settle;
		check({seen, ready}, {{4{CODE_MID}}, 4'h0, 1'b1, 1'b1});
		// Power-up with reset pin low and strobe chatter
		reset = 1'b1;
		hw_reset_n = 1'b0;
		load_strobe_n = 1'b0;
		settle;
		reset = 1'b0;
		settle;
		load_strobe_n = 1'b1;
		settle;
		check({69'h0, ready}, 70'h0);
		hw_reset_n = 1'b1;
		settle;
		check({seen, ready}, {{4{CODE_MID}}, 4'h0, 1'b1, 1'b1});
		report_and_stop;
	end

	// Watchdog well beyond the expected run of about 22 us
	initial begin
		#200000;
		failures++;
		report_and_stop;
	end
endmodule // test_quad_dac_update_and_reset_control
